// ===== byte_fifo.sv
// Small first-in first-out store for received data bytes with offsets.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;

	// Extra pointer bit tells full from empty
	assign inReady  = !((wrPtr[AW] != rdPtr[AW]) &&
		(wrPtr[AW-1:0] == rdPtr[AW-1:0]));
	assign outValid = (wrPtr != rdPtr);
	assign outData  = mem[rdPtr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (inValid && inReady) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr <= '0;
		end else if (inValid && inReady) begin
			wrPtr <= wrPtr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdPtr <= '0;
		end else if (outValid && outReady) begin
			rdPtr <= rdPtr + 1'b1;
		end
	end

endmodule

// ===== flash_buffer_seq.sv
// Serial flash command sequencer for the page buffer, quad page program
// and the three lockable security registers.
// Assumes the serial clock, chip select and data lines arrive unsynchronised
// and much slower than sys_clk; the array itself sits behind the arr ports.
`timescale 1ns/10ps

// Notes on behaviour
// - Quad program needs latch and quad bit
// - Quad program: opcode, address, quad data
// - Quad program otherwise same as page program
// - Page data wraps within 256 bytes
// - Program end clears busy and latch
// - Buffer clear fills FF, blocks during latency
// - Buffer load copies addressed page
// - Busy shown during page load
// - Buffer read: address, dummy, data out
// - Read address increments and rolls over
// - Buffer read rejected while cycle runs
// - Buffer write stores upward with wrap
// - Buffer to array needs latch, page
// - Buffer program self-timed, then clears flags
// - Protected page blocks buffer program
// - Three security registers, fixed address form
// - Security erase needs latch, self-timed
// - Erase only on exact byte boundary
// - Locked register ignores erase
// - Security program needs latch, self-timed
// - Locked register ignores program
module flash_buffer_seq #(
	parameter int CLEAR_CYCLES = flash_seq_pkg::CLEAR_CYC,
	parameter int XFER_CYCLES  = flash_seq_pkg::XFER_CYC,
	parameter int PROG_CYCLES  = flash_seq_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYC
) (
	// System
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Serial link pins
	input  wire logic        chipSelectN,
	input  wire logic        serialClock,
	input  wire logic [3:0]  quadDataIn,
	output logic      [3:0]  quadDataOut,
	output logic      [3:0]  quadDataOe,
	// Status and configuration
	input  wire logic        quadEnableBit,
	input  wire logic [4:0]  blockProtectBits,
	input  wire logic [2:0]  secureRegLockBits,
	output logic             writeInProgress,
	output logic             writeEnableLatch,
	output logic             deviceBusy,
	output logic             dataDropped,
	// Array side
	output logic             arrStart,
	output logic      [2:0]  arrOp,
	output logic      [23:0] arrAddr,
	input  wire logic [7:0]  arrBufAddr,
	output logic      [7:0]  arrBufData,
	output logic             arrBufMask,
	input  wire logic        loadValid,
	input  wire logic [7:0]  loadOffset,
	input  wire logic [7:0]  loadData
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] csSync;
	logic [2:0] sclkSync;
	logic [3:0] dataSync [3];
	logic       csLevelN;
	logic       sclkLevel;
	logic [3:0] dataLevel;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			csSync   <= 3'h7;
			sclkSync <= 3'h0;
		end else begin
			csSync   <= {csSync[1:0], chipSelectN};
			sclkSync <= {sclkSync[1:0], serialClock};
		end
		dataSync[0] <= quadDataIn;
		dataSync[1] <= dataSync[0];
		dataSync[2] <= dataSync[1];
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			csLevelN  <= 1'b1;
			sclkLevel <= 1'b0;
			dataLevel <= 4'h0;
		end else begin
			if (csSync[1] == csSync[2]) begin
				csLevelN <= csSync[2];
			end
			if (sclkSync[1] == sclkSync[2]) begin
				sclkLevel <= sclkSync[2];
			end
			for (int i = 0; i < 4; i++) begin
				if (dataSync[1][i] == dataSync[2][i]) begin
					dataLevel[i] <= dataSync[2][i];
				end
			end
		end
	end

	logic csRise;
	logic csFall;
	logic sclkRise;
	logic sclkFall;
	assign csRise = (csSync[1] == csSync[2]) && csSync[2] && !csLevelN;
	assign csFall = (csSync[1] == csSync[2]) && !csSync[2] && csLevelN;
	assign sclkRise = (sclkSync[1] == sclkSync[2]) && sclkSync[2] &&
		!sclkLevel && !csLevelN;
	assign sclkFall = (sclkSync[1] == sclkSync[2]) && !sclkSync[2] &&
		sclkLevel && !csLevelN;

	// ****************************************
	// Frame decode
	// ****************************************
	flash_seq_pkg::cycle_t cycle;
	logic [7:0]  opcode;
	logic [23:0] addr;
	logic [2:0]  bitCnt;
	logic [2:0]  byteCnt;
	logic [7:0]  shiftIn;
	logic [7:0]  bytePtr;
	logic        frameIgnored;
	logic [7:0]  outShift;
	logic [2:0]  outBit;
	logic        soBit;
	logic        soOe;
	logic [7:0]  bufRdData;
	logic        quadPhase;
	logic        byteDone;
	logic        readPhase;
	logic        writeOp;
	logic        pushByte;
	logic        fifoInReady;
	logic [7:0]  next_shift;
	logic [2:0]  next_bitCnt;

	assign quadPhase = (opcode == flash_seq_pkg::OP_QUAD_PAGE_PROGRAM) &&
		(byteCnt >= flash_seq_pkg::CNT_ADDR);
	assign next_shift = quadPhase ? {shiftIn[3:0], dataLevel} :
		{shiftIn[6:0], dataLevel[0]};
	assign next_bitCnt = quadPhase ? bitCnt + 3'h4 : bitCnt + 3'h1;
	assign byteDone = sclkRise && !frameIgnored && (quadPhase ?
		(bitCnt == flash_seq_pkg::NIBBLE_LAST) :
		(bitCnt == flash_seq_pkg::BIT_LAST));
	assign writeOp = (opcode == flash_seq_pkg::OP_QUAD_PAGE_PROGRAM) ||
		(opcode == flash_seq_pkg::OP_BUF_WRITE) ||
		(opcode == flash_seq_pkg::OP_SECURE_REG_PROG);
	assign pushByte = byteDone && writeOp &&
		(byteCnt >= flash_seq_pkg::CNT_ADDR);
	// data out after address and dummy
	assign readPhase = (opcode == flash_seq_pkg::OP_BUF_READ) &&
		(byteCnt == flash_seq_pkg::CNT_DATA) && !frameIgnored;

	always_ff @(posedge sys_clk) begin
		if (srst || csFall) begin
			opcode  <= 8'h00;
			addr    <= 24'h000000;
			bitCnt  <= 3'h0;
			byteCnt <= 3'h0;
			shiftIn <= 8'h00;
			bytePtr <= 8'h00;
		end else if (sclkRise && !frameIgnored) begin
			shiftIn <= next_shift;
			bitCnt  <= next_bitCnt;
			if (byteDone) begin
				if (byteCnt == 3'h0) begin
					opcode <= next_shift;
				end else if (byteCnt < flash_seq_pkg::CNT_ADDR) begin
					addr <= {addr[15:0], next_shift};
				end
				if (byteCnt == flash_seq_pkg::CNT_ADDR - 3'h1) begin
					bytePtr <= next_shift;
				end else if (pushByte) begin
					bytePtr <= bytePtr + 8'h01;
				end
				if (byteCnt != flash_seq_pkg::CNT_DATA) begin
					byteCnt <= byteCnt + 3'h1;
				end
			end
		end else if (sclkFall && readPhase && outBit == 3'h0) begin
			bytePtr <= bytePtr + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			frameIgnored <= 1'b0;
		end else if (csFall) begin
			frameIgnored <= (cycle != flash_seq_pkg::CYC_IDLE);
		end
	end

	// Set wins over the clear at a new frame
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dataDropped <= 1'b0;
		end else if (pushByte && !fifoInReady) begin
			dataDropped <= 1'b1;
		end else if (csFall) begin
			dataDropped <= 1'b0;
		end
	end

	// ****************************************
	// Read data out
	// ****************************************
	// Host samples on the rising edge, so bits change on the falling one
	always_ff @(posedge sys_clk) begin
		if (srst || csFall) begin
			outShift <= 8'h00;
			outBit   <= 3'h0;
			soBit    <= 1'b0;
		end else if (sclkFall && readPhase) begin
			outBit <= outBit + 3'h1;
			if (outBit == 3'h0) begin
				soBit    <= bufRdData[7];
				outShift <= {bufRdData[6:0], 1'b0};
			end else begin
				soBit    <= outShift[7];
				outShift <= {outShift[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			soOe <= 1'b0;
		end else begin
			soOe <= readPhase && !csLevelN;
		end
	end

	assign quadDataOut = {2'b00, soBit, 1'b0};
	assign quadDataOe  = {2'b00, soOe, 1'b0};

	// ****************************************
	// Data path and buffer
	// ****************************************
	logic [15:0]  fifoOut;
	logic         fifoOutValid;
	logic         fifoOutReady;
	logic [7:0]   dataBuffer [256];
	logic [255:0] byteMask;
	logic [7:0]   clearIdx;
	logic [7:0]   rdAddr;

	byte_fifo #(
		.WIDTH (flash_seq_pkg::FIFO_WIDTH),
		.DEPTH (flash_seq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (sys_clk),
		.srst     (srst),
		.inValid  (pushByte),
		.inReady  (fifoInReady),
		.inData   ({bytePtr, next_shift}),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOut)
	);

	// Clearing and loading own the buffer port; the drain waits
	assign fifoOutReady = (cycle != flash_seq_pkg::CYC_CLEAR) &&
		!(loadValid && cycle == flash_seq_pkg::CYC_LOAD);

	always_ff @(posedge sys_clk) begin
		if (cycle == flash_seq_pkg::CYC_CLEAR) begin
			dataBuffer[clearIdx] <= flash_seq_pkg::BUF_FILL;
		end else if (loadValid && cycle == flash_seq_pkg::CYC_LOAD) begin
			dataBuffer[loadOffset] <= loadData;
		end else if (fifoOutValid) begin
			dataBuffer[fifoOut[15:8]] <= fifoOut[7:0];
		end
	end

	// Only the last byte written to each offset survives
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			byteMask <= '0;
		end else begin
			if (csFall && cycle == flash_seq_pkg::CYC_IDLE) begin
				byteMask <= '0;
			end
			if (fifoOutValid && fifoOutReady) begin
				byteMask[fifoOut[15:8]] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || cycle != flash_seq_pkg::CYC_CLEAR) begin
			clearIdx <= 8'h00;
		end else if (clearIdx != 8'hff) begin
			clearIdx <= clearIdx + 8'h01;
		end
	end

	assign rdAddr = (cycle == flash_seq_pkg::CYC_IDLE) ? bytePtr : arrBufAddr;

	always_ff @(posedge sys_clk) begin
		bufRdData  <= dataBuffer[rdAddr];
		arrBufMask <= byteMask[rdAddr];
	end

	assign arrBufData = bufRdData;

	// ****************************************
	// Self-timed cycles
	// ****************************************
	logic [23:0] timer;
	logic        boundary;
	logic        protect;
	logic        secAddrOk;
	logic        secLocked;

	assign boundary = csRise && !frameIgnored && (bitCnt == 3'h0);
	// Any protect setting covers the whole array
	assign protect = (blockProtectBits != 5'h00);
	assign secAddrOk = (addr[23:16] == flash_seq_pkg::SEC_HIGH) &&
		(addr[15:12] >= flash_seq_pkg::SEC_REG_LOW) &&
		(addr[15:12] <= flash_seq_pkg::SEC_REG_HIGH) &&
		(addr[11:9] == flash_seq_pkg::SEC_GAP);
	assign secLocked = (addr[13:12] == 2'h1 && secureRegLockBits[0]) ||
		(addr[13:12] == 2'h2 && secureRegLockBits[1]) ||
		(addr[13:12] == 2'h3 && secureRegLockBits[2]);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cycle            <= flash_seq_pkg::CYC_IDLE;
			timer            <= 24'h000000;
			writeEnableLatch <= 1'b0;
			arrStart         <= 1'b0;
			arrOp            <= flash_seq_pkg::ARR_PROG_FULL;
			arrAddr          <= 24'h000000;
		end else begin
			arrStart <= 1'b0;
			case (cycle)
			flash_seq_pkg::CYC_IDLE: begin
				if (boundary) begin
					arrAddr <= addr;
					if (opcode == flash_seq_pkg::OP_WRITE_ENABLE &&
						byteCnt == flash_seq_pkg::CNT_OPCODE) begin
						writeEnableLatch <= 1'b1;
					end else if (opcode == flash_seq_pkg::OP_BUF_CLEAR &&
						byteCnt == flash_seq_pkg::CNT_OPCODE) begin
						cycle <= flash_seq_pkg::CYC_CLEAR;
						timer <= 24'(CLEAR_CYCLES);
					end else if (opcode == flash_seq_pkg::OP_BUF_LOAD &&
						byteCnt == flash_seq_pkg::CNT_ADDR) begin
						cycle    <= flash_seq_pkg::CYC_LOAD;
						timer    <= 24'(XFER_CYCLES);
						arrOp    <= flash_seq_pkg::ARR_LOAD;
						arrStart <= 1'b1;
					end else if (opcode == flash_seq_pkg::OP_BUF_TO_ARRAY &&
						byteCnt == flash_seq_pkg::CNT_ADDR &&
						writeEnableLatch && !protect) begin
						cycle    <= flash_seq_pkg::CYC_PROGRAM;
						timer    <= 24'(PROG_CYCLES);
						arrOp    <= flash_seq_pkg::ARR_PROG_FULL;
						arrStart <= 1'b1;
					// latch and quad bit, same checks
					end else if (opcode ==
						flash_seq_pkg::OP_QUAD_PAGE_PROGRAM &&
						byteCnt == flash_seq_pkg::CNT_DATA &&
						writeEnableLatch && quadEnableBit && !protect) begin
						cycle    <= flash_seq_pkg::CYC_PROGRAM;
						timer    <= 24'(PROG_CYCLES);
						arrOp    <= flash_seq_pkg::ARR_PROG_MASKED;
						arrStart <= 1'b1;
					end else if (opcode ==
						flash_seq_pkg::OP_SECURE_REG_ERASE &&
						byteCnt == flash_seq_pkg::CNT_ADDR &&
						writeEnableLatch && secAddrOk && !secLocked) begin
						cycle    <= flash_seq_pkg::CYC_ERASE;
						timer    <= 24'(ERASE_CYCLES);
						arrOp    <= flash_seq_pkg::ARR_SEC_ERASE;
						arrStart <= 1'b1;
					end else if (opcode ==
						flash_seq_pkg::OP_SECURE_REG_PROG &&
						byteCnt == flash_seq_pkg::CNT_DATA &&
						writeEnableLatch && secAddrOk && !secLocked) begin
						cycle    <= flash_seq_pkg::CYC_PROGRAM;
						timer    <= 24'(PROG_CYCLES);
						arrOp    <= flash_seq_pkg::ARR_SEC_PROG;
						arrStart <= 1'b1;
					end
				end
			end
			flash_seq_pkg::CYC_CLEAR,
			flash_seq_pkg::CYC_LOAD: begin
				timer <= timer - 24'h000001;
				if (timer <= 24'h000001) begin
					cycle <= flash_seq_pkg::CYC_IDLE;
				end
			end
			flash_seq_pkg::CYC_PROGRAM,
			flash_seq_pkg::CYC_ERASE: begin
				timer <= timer - 24'h000001;
				if (timer <= 24'h000001) begin
					cycle            <= flash_seq_pkg::CYC_IDLE;
					writeEnableLatch <= 1'b0;
				end
			end
			default: begin
				cycle <= flash_seq_pkg::CYC_IDLE;
			end
			endcase
		end
	end

	assign writeInProgress = (cycle == flash_seq_pkg::CYC_LOAD) ||
		(cycle == flash_seq_pkg::CYC_PROGRAM) ||
		(cycle == flash_seq_pkg::CYC_ERASE);
	assign deviceBusy = (cycle != flash_seq_pkg::CYC_IDLE);

endmodule

// ===== flash_buffer_seq_checker.sv
// Assertions on the ports of the flash buffer command block.
// Assumes it is bound to flash_buffer_seq with its cycle parameters.
`timescale 1ns/10ps
module flash_buffer_seq_checker #(
	parameter int XFER_CYCLES  = 20,
	parameter int PROG_CYCLES  = 50,
	parameter int ERASE_CYCLES = 60
) (
	// System
	input wire logic        sys_clk,
	input wire logic        srst,
	// Status and configuration
	input wire logic        quadEnableBit,
	input wire logic [4:0]  blockProtectBits,
	input wire logic [2:0]  secureRegLockBits,
	input wire logic        writeInProgress,
	input wire logic        writeEnableLatch,
	// Link and array
	input wire logic [3:0]  quadDataOe,
	input wire logic        arrStart,
	input wire logic [2:0]  arrOp,
	input wire logic [23:0] arrAddr
);
	// ****
	// Helpers
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	int         wipCnt;
	logic [2:0] opSeen;
	logic       isSec;
	assign isSec = arrStart && arrOp inside {3'h3, 3'h4};
	always_ff @(posedge sys_clk)
		if (srst || !writeInProgress) wipCnt <= 0;
		else wipCnt <= wipCnt + 1;
	// Kept so that the end of a cycle knows its length
	always_ff @(posedge sys_clk)
		if (srst) opSeen <= 3'h1;
		else if (arrStart) opSeen <= arrOp;
	// ****
	// Properties
	// ****
	property p_start_busy;
		arrStart |-> writeInProgress;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("cycle start without busy");
	property p_cyc_len;
		$fell(writeInProgress) |-> wipCnt == (opSeen == 3'h3 ? ERASE_CYCLES
			: opSeen == 3'h2 ? XFER_CYCLES : PROG_CYCLES);
	endproperty
	a_cyc_len: assert property (p_cyc_len)
		else $error("cycle length wrong");
	property p_latch_end;
		$fell(writeInProgress) && opSeen != 3'h2 |-> !writeEnableLatch;
	endproperty
	a_latch_end: assert property (p_latch_end)
		else $error("latch kept after cycle");
	property p_need_latch;
		arrStart && arrOp != 3'h2 |-> writeEnableLatch
			&& (arrOp != 3'h0 || quadEnableBit);
	endproperty
	a_need_latch: assert property (p_need_latch)
		else $error("cycle without latch");
	property p_protect;
		arrStart && arrOp inside {3'h0, 3'h1} |-> blockProtectBits == 5'h0;
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected page programmed");
	property p_sec_addr;
		isSec |-> arrAddr[23:16] == 8'h00 && arrAddr[11:9] == 3'h0
			&& arrAddr[15:12] inside {[4'h1:4'h3]};
	endproperty
	a_sec_addr: assert property (p_sec_addr)
		else $error("bad security address");
	property p_sec_lock;
		isSec |-> !secureRegLockBits[arrAddr[13:12] - 2'h1];
	endproperty
	a_sec_lock: assert property (p_sec_lock)
		else $error("locked register changed");
	property p_no_read;
		writeInProgress |-> quadDataOe == 4'h0;
	endproperty
	a_no_read: assert property (p_no_read)
		else $error("read served while busy");
endmodule

bind flash_buffer_seq flash_buffer_seq_checker #(
	.XFER_CYCLES(XFER_CYCLES), .PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)
) u_flash_buffer_seq_checker (
	.sys_clk(sys_clk), .srst(srst), .quadEnableBit(quadEnableBit),
	.blockProtectBits(blockProtectBits), .quadDataOe(quadDataOe),
	.secureRegLockBits(secureRegLockBits), .arrAddr(arrAddr),
	.writeInProgress(writeInProgress), .arrStart(arrStart),
	.writeEnableLatch(writeEnableLatch), .arrOp(arrOp)
);

// ===== flash_buffer_seq_test.sv
// Self-checking bench for the flash buffer command block.
// Assumes the host model, a bench-driven array side and short cycles.
`timescale 1ns/10ps
module flash_buffer_seq_test;
	// ****
	// Signals
	// ****
	logic        sysClk = 1'b0;
	logic        srst, chipSelectN, serialClock, quadEnableBit, arrStart;
	logic        writeInProgress, writeEnableLatch, deviceBusy, dataDropped;
	logic        arrBufMask, loadValid;
	logic [3:0]  quadDataIn, quadDataOut, quadDataOe;
	logic [4:0]  blockProtectBits;
	logic [2:0]  secureRegLockBits, arrOp, lastOp;
	logic [23:0] arrAddr, lastAddr;
	logic [7:0]  arrBufAddr, arrBufData, loadOffset, loadData, d;
	logic [15:0] pg;
	logic [7:0]  expBuf [256];
	logic [7:0]  tx[$], rxQ[$];
	int          bad_count, n_checks, cycles, starts;
	always #50 sysClk = ~sysClk;
	flash_buffer_seq #(.CLEAR_CYCLES(300), .XFER_CYCLES(300),
		.PROG_CYCLES(600), .ERASE_CYCLES(60)) u_flash_buffer_seq (
		.sys_clk(sysClk), .srst(srst), .chipSelectN(chipSelectN),
		.serialClock(serialClock), .quadDataIn(quadDataIn),
		.quadDataOut(quadDataOut), .quadDataOe(quadDataOe),
		.quadEnableBit(quadEnableBit), .blockProtectBits(blockProtectBits),
		.secureRegLockBits(secureRegLockBits), .deviceBusy(deviceBusy),
		.writeInProgress(writeInProgress), .dataDropped(dataDropped),
		.writeEnableLatch(writeEnableLatch), .arrStart(arrStart),
		.arrOp(arrOp), .arrAddr(arrAddr), .arrBufAddr(arrBufAddr),
		.arrBufData(arrBufData), .arrBufMask(arrBufMask),
		.loadValid(loadValid), .loadOffset(loadOffset), .loadData(loadData));
	spi_host_model u_spi_host_model (.sysClk(sysClk),
		.chipSelectN(chipSelectN), .serialClock(serialClock),
		.quadDataIn(quadDataIn), .quadDataOut(quadDataOut),
		.quadDataOe(quadDataOe));
	// ****
	// Tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic idle();
		for (int n = 0; n < 3000 && deviceBusy !== 1'b0; n++)
			@(negedge sysClk);
	endtask
	task automatic write_enable_cmd();
		logic [7:0] w[$];
		w = {8'h06};
		u_spi_host_model.frame(w, 99, 0, 0, rxQ);
		check(writeEnableLatch, 1'b1);
	endtask
	task automatic run(input int qf, input int xb, input logic go,
		input logic [2:0] op);
		int s0;
		s0 = starts;
		u_spi_host_model.frame(tx, qf, 0, xb, rxQ);
		check(starts - s0, go);
		if (go) begin
			check(lastOp, op);
			check(lastAddr, {tx[1], tx[2], tx[3]});
		end
	endtask
	task automatic bufRead(input logic [7:0] a, input int n);
		logic [7:0] q[$];
		q = {8'h9b, 8'h00, 8'h00, a, 8'h00};
		u_spi_host_model.frame(q, 99, n, 0, rxQ);
		foreach (rxQ[i]) check(rxQ[i], expBuf[8'(a + i)]);
	endtask
	task automatic peek(input logic [7:0] a, input logic [7:0] e,
		input logic m);
		arrBufAddr = a;
		repeat (2) @(negedge sysClk);
		check(arrBufData, e);
		check(arrBufMask, m);
	endtask
	always @(posedge sysClk) begin
		cycles <= cycles + 1;
		if (arrStart === 1'b1) begin
			starts <= starts + 1;
			lastOp <= arrOp;
			lastAddr <= arrAddr;
		end
		if (cycles == 40000) begin
			bad_count++;
			test_done();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(32'h20daac90));
		{srst, quadEnableBit, loadValid} = 3'h4;
		{blockProtectBits, secureRegLockBits, arrBufAddr} = 16'h0;
		{loadOffset, loadData} = 16'h0;
		repeat (2) @(negedge sysClk);
		srst = 1'b0;
		repeat (4) @(negedge sysClk);
		check(arrOp, 3'h1);
		check(writeInProgress | writeEnableLatch | deviceBusy, 1'b0);
		tx = {8'h9e};
		run(99, 0, 1'b0, 3'h0);
		check(deviceBusy, 1'b1);
		tx = {8'h06};
		run(99, 0, 1'b0, 3'h0);
		check(writeEnableLatch, 1'b0);
		idle();
		foreach (expBuf[i]) expBuf[i] = 8'hff;
		bufRead(8'($urandom), 3);
		tx = {8'h9c, 8'h00, 8'h00, 8'hfd};
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			tx.push_back(d);
			expBuf[8'(253 + i)] = d;
		end
		run(99, 0, 1'b0, 3'h0);
		bufRead(8'hfc, 8);
		pg = 16'($urandom);
		tx = {8'h9a, pg[15:8], pg[7:0], 8'h00};
		run(99, 0, 1'b1, 3'h2);
		check(writeInProgress, 1'b1);
		loadValid = 1'b1;
		for (int i = 0; i < 256; i++) begin
			loadOffset = 8'(i);
			loadData = pg[7:0] ^ 8'(i);
			expBuf[i] = loadData;
			@(negedge sysClk);
		end
		loadValid = 1'b0;
		idle();
		check(writeInProgress, 1'b0);
		bufRead(8'($urandom), 3);
		tx = {8'h9d, 8'h01, 8'h02, 8'h00};
		run(99, 0, 1'b0, 3'h1);
		write_enable_cmd();
		blockProtectBits = 5'($urandom_range(1, 31));
		run(99, 0, 1'b0, 3'h1);
		check(writeEnableLatch, 1'b1);
		blockProtectBits = 5'h0;
		run(99, 0, 1'b1, 3'h1);
		peek(8'h07, expBuf[7], 1'b0);
		tx = {8'h9b, 8'h00, 8'h00, 8'h00, 8'h00};
		u_spi_host_model.frame(tx, 99, 1, 0, rxQ);
		check(rxQ[0], 8'hff);
		check(u_spi_host_model.oeSeen, 1'b0);
		check(writeInProgress, 1'b1);
		idle();
		check(writeEnableLatch, 1'b0);
		write_enable_cmd();
		tx = {8'h32, 8'h00, 8'h33, 8'hfe};
		for (int i = 0; i < 3; i++) begin
			d = 8'($urandom);
			tx.push_back(d);
			expBuf[8'(254 + i)] = d;
		end
		run(4, 0, 1'b0, 3'h0);
		quadEnableBit = 1'b1;
		run(4, 0, 1'b1, 3'h0);
		peek(8'h00, expBuf[0], 1'b1);
		peek(8'h10, expBuf[8'h10], 1'b0);
		idle();
		check(writeEnableLatch, 1'b0);
		for (int r = 1; r <= 3; r++) begin
			for (int k = 0; k < 2; k++) begin
				tx = {k ? 8'h42 : 8'h44, 8'h00, 8'(r << 4), 8'($urandom)};
				if (k == 1) tx.push_back(8'($urandom));
				write_enable_cmd();
				secureRegLockBits = 3'h1 << (r - 1);
				run(99, 0, 1'b0, 3'h3);
				secureRegLockBits = ~(3'h1 << (r - 1));
				run(99, 0, 1'b1, k ? 3'h4 : 3'h3);
				idle();
				check(writeEnableLatch, 1'b0);
			end
		end
		secureRegLockBits = 3'h0;
		write_enable_cmd();
		tx = {8'h44, 8'h00, 8'h40, 8'h00};
		run(99, 0, 1'b0, 3'h3);
		tx = {8'h44, 8'h00, 8'h10, 8'h00};
		run(99, 3, 1'b0, 3'h3);
		check(writeEnableLatch, 1'b1);
		// Burst longer than the queue, read back through the buffer
		pg = 16'($urandom);
		tx = {8'h9c, 8'h00, 8'h00, pg[7:0]};
		for (int i = 0; i < 12; i++) begin
			d = 8'($urandom);
			tx.push_back(d);
			expBuf[8'(pg[7:0] + i)] = d;
		end
		run(99, 0, 1'b0, 3'h0);
		check(dataDropped, 1'b0);
		bufRead(pg[7:0], 12);
		test_done();
	end
endmodule

// ===== flash_seq_pkg.sv
// Constants shared by the flash buffer and one-time-lockable command block.
// Assumes a 10 MHz system clock; cycle counts derive from the times below.
package flash_seq_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
	localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] OP_BUF_CLEAR         = 8'h9e;
	localparam logic [7:0] OP_BUF_LOAD          = 8'h9a;
	localparam logic [7:0] OP_BUF_READ          = 8'h9b;
	localparam logic [7:0] OP_BUF_WRITE         = 8'h9c;
	localparam logic [7:0] OP_BUF_TO_ARRAY      = 8'h9d;
	localparam logic [7:0] OP_SECURE_REG_ERASE  = 8'h44;
	localparam logic [7:0] OP_SECURE_REG_PROG   = 8'h42;

	// ****************************************
	// Frame layout
	// ****************************************
	// Byte count after opcode only, after opcode plus address, and
	// the saturated count that marks data bytes
	localparam logic [2:0] CNT_OPCODE   = 3'h1;
	localparam logic [2:0] CNT_ADDR     = 3'h4;
	localparam logic [2:0] CNT_DATA     = 3'h5;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [2:0] NIBBLE_LAST  = 3'h4;
	localparam logic [7:0] BUF_FILL     = 8'hff;
	localparam logic [7:0] SEC_HIGH     = 8'h00;
	localparam logic [3:0] SEC_REG_LOW  = 4'h1;
	localparam logic [3:0] SEC_REG_HIGH = 4'h3;
	localparam logic [2:0] SEC_GAP      = 3'h0;

	// ****************************************
	// Array operations
	// ****************************************
	localparam logic [2:0] ARR_PROG_MASKED = 3'h0;
	localparam logic [2:0] ARR_PROG_FULL   = 3'h1;
	localparam logic [2:0] ARR_LOAD        = 3'h2;
	localparam logic [2:0] ARR_SEC_ERASE   = 3'h3;
	localparam logic [2:0] ARR_SEC_PROG    = 3'h4;

	typedef enum logic [4:0] {
		CYC_IDLE    = 5'h01,
		CYC_CLEAR   = 5'h02,
		CYC_LOAD    = 5'h04,
		CYC_PROGRAM = 5'h08,
		CYC_ERASE   = 5'h10
	} cycle_t;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS           = 100;
	localparam int BUFFER_CLEAR_LATENCY_US = 30;
	localparam int PAGE_TRANSFER_TIME_US   = 30;
	localparam int PAGE_PROGRAM_TIME_US    = 1000;
	localparam int SECTOR_ERASE_TIME_US    = 50000;
	localparam int CLEAR_CYC = (BUFFER_CLEAR_LATENCY_US * 1000
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XFER_CYC = (PAGE_TRANSFER_TIME_US * 1000
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYC = (PAGE_PROGRAM_TIME_US * 1000
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC = (SECTOR_ERASE_TIME_US * 1000
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int FIFO_WIDTH = 16;
	localparam int FIFO_DEPTH = 8;

endpackage

// ===== spi_host_model.sv
// Host controller model driving the flash link, mode 0, MSB first.
// Assumes sysClk from the bench; the link clock runs only in frames.
`timescale 1ns/10ps
module spi_host_model (
	// Clock
	input  wire logic       sysClk,
	// Link pins
	output logic            chipSelectN,
	output logic            serialClock,
	output logic [3:0]      quadDataIn,
	input  wire logic [3:0] quadDataOut,
	input  wire logic [3:0] quadDataOe
);
	logic [7:0] rxByte;
	logic       oeSeen;
	initial begin
		chipSelectN = 1'b1;
		serialClock = 1'b0;
		quadDataIn = 4'h5;
	end
	// Half of the 800 ns link period
	task automatic half();
		repeat (4) @(negedge sysClk);
	endtask
	// Read bit taken late, well after the device shifted it
	task automatic tick(input logic [3:0] v);
		quadDataIn = v;
		half();
		serialClock = 1'b1;
		half();
		// A released output line is taken as pulled high
		rxByte = {rxByte[6:0], quadDataOe[1] ? quadDataOut[1] : 1'b1};
		oeSeen = oeSeen | quadDataOe[1];
		serialClock = 1'b0;
	endtask
	task automatic frame(input logic [7:0] tx[$], input int qf,
		input int nr, input int xb, output logic [7:0] rx[$]);
		rx = {};
		oeSeen = 1'b0;
		chipSelectN = 1'b0;
		half();
		foreach (tx[i]) begin
			if (i >= qf) begin
				tick(tx[i][7:4]);
				tick(tx[i][3:0]);
			end else begin
				for (int b = 7; b >= 0; b--)
					tick({~quadDataIn[3:1], tx[i][b]});
			end
		end
		// data out after the dummy byte
		repeat (nr) begin
			repeat (8) tick(~quadDataIn);
			rx.push_back(rxByte);
		end
		repeat (xb) tick(~quadDataIn);
		half();
		chipSelectN = 1'b1;
		// Released lines must not keep the last value
		quadDataIn = ~quadDataIn;
		repeat (12) @(negedge sysClk);
	endtask
endmodule
